// file: cbs_pkg.sv
// Constants and types shared by the clock buffer SMBus register bank
package cbs_pkg;

	// Synchroniser lane positions
	localparam int unsigned SY_SCL  = 0;
	localparam int unsigned SY_SDA  = 1;
	localparam int unsigned SY_PG   = 2;
	localparam int unsigned SY_REF  = 3;
	localparam int unsigned SY_FREQ = 4;
	localparam int unsigned SY_LOOP = 5;
	localparam int unsigned SY_ADDR = 7;
	localparam int unsigned SY_OE   = 11;
	localparam int unsigned SYNC_W  = 23;

	// Register indices
	localparam logic [7:0] IDX_LOOP   = 8'h00;
	localparam logic [7:0] IDX_OEL    = 8'h01;
	localparam logic [7:0] IDX_OEH    = 8'h02;
	localparam logic [7:0] IDX_RSV_A  = 8'h03;
	localparam logic [7:0] IDX_RSV_B  = 8'h04;
	localparam logic [7:0] IDX_VENREV = 8'h05;
	localparam logic [7:0] IDX_PARTID = 8'h06;
	localparam logic [7:0] IDX_RBCNT  = 8'h07;
	localparam logic [7:0] IDX_RSV_C  = 8'h08;

	// Field positions in the loop mode register
	localparam int unsigned POS_RB_LOOP = 6;
	localparam int unsigned POS_SW_SEL  = 3;
	localparam int unsigned POS_SW_MODE = 1;
	localparam int unsigned POS_FREQ    = 0;

	// Values after reset
	localparam logic       RST_SW_SEL  = 1'b0;
	localparam logic [1:0] RST_SW_MODE = 2'h3;
	localparam logic [7:0] RST_OE_LOW  = 8'hFF;
	localparam logic [3:0] RST_OE_HIGH = 4'hF;
	localparam logic [4:0] RST_RBCNT   = 5'h08;

	// Loop mode codes, shared by readback and software control
	localparam logic [1:0] LOOP_LOW  = 2'h0;
	localparam logic [1:0] LOOP_BYP  = 2'h1;
	localparam logic [1:0] LOOP_HIGH = 2'h3;

	// Tri-level address strap codes and address base
	localparam logic [1:0] TRI_LOW  = 2'h0;
	localparam logic [1:0] TRI_MID  = 2'h1;
	localparam logic [6:0] ADDR_BASE = 7'h58;

	// Bit counter marks within a byte frame
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_INDEX = 7'h04,
		ST_COUNT = 7'h08,
		ST_WRITE = 7'h10,
		ST_READ  = 7'h20,
		ST_HALT  = 7'h40
	} cbs_state_t;

endpackage

// file: cbs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module cbs_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_r <= '0;
			syncOut  <= '0;
		end else begin
			stage1_r <= asyncIn;
			syncOut  <= stage1_r;
		end
	end

endmodule // cbs_sync

// file: cbs_smbus_regs.sv
// SMBus target and register bank of a twelve-output clock buffer
`timescale 1ns/1ps
module cbs_smbus_regs
	import cbs_pkg::*;
#(
	parameter logic       SECOND_REV = 1'b1,
	parameter logic [3:0] REV_CODE   = 4'h2, // Arbitrary value
	parameter logic [3:0] VENDOR_ID  = 4'h5, // Arbitrary value
	parameter logic [7:0] PART_ID    = 8'h5A // Arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic [1:0]  addrSelA0,
	input  wire logic [1:0]  addrSelA1,
	input  wire logic        powergoodPowerdown_n,
	input  wire logic        refClockRunning,
	input  wire logic        freqSelectPin,
	input  wire logic [1:0]  loopBandwidthSelectPin,
	input  wire logic [11:0] outputEnablePin_n,
	output logic [11:0]      diffClockRun,
	output logic             feedbackClockRun,
	output logic [1:0]       loopMode,
	output logic             freqSelect
);

	logic [SYNC_W-1:0] syncOut;
	logic              sclD_r;
	logic              sdaD_r;
	logic              pgD_r;
	logic              strapDone_r;
	logic [1:0]        loopLatch_r;
	logic              freqLatch_r;

	cbs_state_t        state_r;
	cbs_state_t        state_nxt;
	logic [3:0]        bitCnt_r;
	logic [3:0]        bitCnt_nxt;
	logic [7:0]        shift_r;
	logic [7:0]        shift_nxt;
	logic [7:0]        tx_r;
	logic [7:0]        tx_nxt;
	logic [7:0]        index_r;
	logic [7:0]        index_nxt;
	logic [7:0]        wrLeft_r;
	logic [7:0]        wrLeft_nxt;
	logic              sdaLow_r;
	logic              sdaLow_nxt;
	logic              hostAck_r;
	logic              hostAck_nxt;
	logic              cntSent_r;
	logic              cntSent_nxt;
	logic              wrEn;

	logic              swSel_r;
	logic [1:0]        swMode_r;
	logic [7:0]        oeLow_r;
	logic [3:0]        oeHigh_r;
	logic [4:0]        rbCnt_r;
	logic [11:0]       pairRun_r;
	logic              fbRun_r;
	logic [1:0]        loopMode_r;
	logic              freqSel_r;

	cbs_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.asyncIn ({outputEnablePin_n, addrSelA1, addrSelA0, loopBandwidthSelectPin,
			freqSelectPin, refClockRunning, powergoodPowerdown_n, sdaIn, sclIn}),
		.syncOut (syncOut)
	);

	// Synchronised views
	wire        sclS   = syncOut[SY_SCL];
	wire        sdaS   = syncOut[SY_SDA];
	wire        pgS    = syncOut[SY_PG];
	wire        refRun = syncOut[SY_REF];
	wire [1:0]  a0S    = syncOut[SY_ADDR +: 2];
	wire [1:0]  a1S    = syncOut[SY_ADDR + 2 +: 2];
	wire [11:0] oeS_n  = syncOut[SY_OE +: 12];

	// Bus events seen on the sampled lines
	wire sclRise   = sclS & ~sclD_r;
	wire sclFall   = ~sclS & sclD_r;
	wire startCond = sclS & sclD_r & sdaD_r & ~sdaS;
	wire stopCond  = sclS & sclD_r & ~sdaD_r & sdaS;
	wire pgRise    = pgS & ~pgD_r;

	// Target address from the two tri-level straps
	wire [1:0] a0Lvl = (a0S == TRI_LOW) ? 2'h0 : (a0S == TRI_MID) ? 2'h1 : 2'h2;
	wire [1:0] a1Lvl = (a1S == TRI_LOW) ? 2'h0 : (a1S == TRI_MID) ? 2'h1 : 2'h2;
	wire [6:0] myAddr = ADDR_BASE + 7'({a1Lvl, 1'b0}) + 7'(a1Lvl) + 7'(a0Lvl);
	wire       addrHit = shift_r[7:1] == myAddr;

	wire rxState = (state_r == ST_ADDR) || (state_r == ST_INDEX) ||
		(state_r == ST_COUNT) || (state_r == ST_WRITE);
	wire swActive = SECOND_REV & swSel_r;
	wire [1:0] loopEff = swActive ? swMode_r : loopLatch_r;
	wire [7:0] countByte = 8'(rbCnt_r) + 8'h01;

	// Register readback; unlisted indices read zero
	function automatic logic [7:0] regRead(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			IDX_LOOP: begin
				v[POS_RB_LOOP +: 2] = loopLatch_r;
				v[POS_FREQ] = freqLatch_r;
				if (SECOND_REV) begin
					v[POS_SW_SEL] = swSel_r;
					v[POS_SW_MODE +: 2] = swMode_r;
				end
			end
			IDX_OEL:    v = oeLow_r;
			IDX_OEH:    v = {4'h0, oeHigh_r};
			IDX_VENREV: v = {REV_CODE, VENDOR_ID};
			IDX_PARTID: v = PART_ID;
			IDX_RBCNT:  v = {3'h0, rbCnt_r};
			default:    v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		state_nxt   = state_r;
		bitCnt_nxt  = bitCnt_r;
		shift_nxt   = shift_r;
		tx_nxt      = tx_r;
		index_nxt   = index_r;
		wrLeft_nxt  = wrLeft_r;
		sdaLow_nxt  = sdaLow_r;
		hostAck_nxt = hostAck_r;
		cntSent_nxt = cntSent_r;
		wrEn        = 1'b0;
		if (!refRun) begin
			state_nxt  = ST_IDLE;
			sdaLow_nxt = 1'b0;
		end else if (startCond) begin
			state_nxt  = ST_ADDR;
			bitCnt_nxt = 4'h0;
			sdaLow_nxt = 1'b0;
		end else if (stopCond) begin
			state_nxt  = ST_IDLE;
			sdaLow_nxt = 1'b0;
		end else if (rxState) begin
			if (sclRise && bitCnt_r < BIT_ACK) begin
				shift_nxt  = {shift_r[6:0], sdaS};
				bitCnt_nxt = bitCnt_r + 4'h1;
			end else if (sclFall && bitCnt_r == BIT_ACK) begin
				bitCnt_nxt = BIT_END;
				sdaLow_nxt = 1'b1;
				unique case (state_r)
					ST_ADDR: begin
						if (!addrHit) begin
							sdaLow_nxt = 1'b0;
							state_nxt  = ST_HALT;
						end else if (shift_r[0]) begin
							state_nxt   = ST_READ;
							cntSent_nxt = 1'b0;
						end else begin
							state_nxt = ST_INDEX;
						end
					end
					ST_INDEX: begin
						index_nxt = shift_r;
						state_nxt = ST_COUNT;
					end
					ST_COUNT: begin
						wrLeft_nxt = shift_r;
						state_nxt  = ST_WRITE;
					end
					default: begin
						if (wrLeft_r != 8'h00) begin
							wrEn       = 1'b1;
							index_nxt  = index_r + 8'h01;
							wrLeft_nxt = wrLeft_r - 8'h01;
						end
					end
				endcase
			end else if (sclFall && bitCnt_r == BIT_END) begin
				sdaLow_nxt = 1'b0;
				bitCnt_nxt = 4'h0;
			end
		end else if (state_r == ST_READ) begin
			if (sclRise && bitCnt_r < BIT_ACK) begin
				bitCnt_nxt = bitCnt_r + 4'h1;
			end else if (sclRise && bitCnt_r == BIT_END && cntSent_r) begin
				hostAck_nxt = ~sdaS;
			end else if (sclFall && bitCnt_r != 4'h0 && bitCnt_r < BIT_ACK) begin
				tx_nxt     = {tx_r[6:0], 1'b0};
				sdaLow_nxt = ~tx_r[6];
			end else if (sclFall && bitCnt_r == BIT_ACK) begin
				sdaLow_nxt = 1'b0;
				bitCnt_nxt = BIT_END;
			end else if (sclFall && bitCnt_r == BIT_END) begin
				if (!cntSent_r || hostAck_r) begin
					tx_nxt      = cntSent_r ? regRead(index_r) : countByte;
					index_nxt   = cntSent_r ? index_r + 8'h01 : index_r;
					cntSent_nxt = 1'b1;
					// First bit of the new byte goes out at once
					sdaLow_nxt  = ~tx_nxt[7];
					bitCnt_nxt  = 4'h0;
				end else begin
					state_nxt  = ST_HALT;
					sdaLow_nxt = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
			pgD_r  <= 1'b0;
		end else begin
			sclD_r <= sclS;
			sdaD_r <= sdaS;
			pgD_r  <= pgS;
		end
	end

	// Straps are caught on the first power-good rise only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strapDone_r <= 1'b0;
			loopLatch_r <= LOOP_LOW;
			freqLatch_r <= 1'b0;
		end else if (pgRise && !strapDone_r) begin
			strapDone_r <= 1'b1;
			loopLatch_r <= syncOut[SY_LOOP +: 2];
			freqLatch_r <= syncOut[SY_FREQ];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r   <= ST_IDLE;
			bitCnt_r  <= 4'h0;
			shift_r   <= 8'h00;
			tx_r      <= 8'h00;
			index_r   <= 8'h00;
			wrLeft_r  <= 8'h00;
			sdaLow_r  <= 1'b0;
			hostAck_r <= 1'b0;
			cntSent_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			bitCnt_r  <= bitCnt_nxt;
			shift_r   <= shift_nxt;
			tx_r      <= tx_nxt;
			index_r   <= index_nxt;
			wrLeft_r  <= wrLeft_nxt;
			sdaLow_r  <= sdaLow_nxt;
			hostAck_r <= hostAck_nxt;
			cntSent_r <= cntSent_nxt;
		end
	end

	// Writable fields; other bits and indices drop the write
	wire wrLoop = wrEn && index_r == IDX_LOOP && SECOND_REV;
	wire wrOel  = wrEn && index_r == IDX_OEL;
	wire wrOeh  = wrEn && index_r == IDX_OEH;
	wire wrCnt  = wrEn && index_r == IDX_RBCNT;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			swSel_r  <= RST_SW_SEL;
			swMode_r <= RST_SW_MODE;
			oeLow_r  <= RST_OE_LOW;
			oeHigh_r <= RST_OE_HIGH;
			rbCnt_r  <= RST_RBCNT;
		end else begin
			if (wrLoop) begin
				swSel_r  <= shift_r[POS_SW_SEL];
				swMode_r <= shift_r[POS_SW_MODE +: 2];
			end
			if (wrOel) begin
				oeLow_r <= shift_r;
			end
			if (wrOeh) begin
				oeHigh_r <= shift_r[3:0];
			end
			if (wrCnt) begin
				rbCnt_r <= shift_r[4:0];
			end
		end
	end

	// Output gating: power-good and reference clock; the pairs also by enable bit and pin
	wire        clkOk   = pgS & refRun;
	wire [11:0] pairNxt = {12{clkOk}} & {oeHigh_r, oeLow_r} & ~oeS_n;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pairRun_r  <= 12'h000;
			fbRun_r    <= 1'b0;
			loopMode_r <= LOOP_LOW;
			freqSel_r  <= 1'b0;
		end else begin
			pairRun_r  <= pairNxt;
			fbRun_r    <= clkOk;
			loopMode_r <= loopEff;
			freqSel_r  <= freqLatch_r;
		end
	end

	assign sdaOut           = 1'b0;
	assign sdaOe            = sdaLow_r;
	assign diffClockRun     = pairRun_r;
	assign feedbackClockRun = fbRun_r;
	assign loopMode         = loopMode_r;
	assign freqSelect       = freqSel_r;

endmodule // cbs_smbus_regs

// file: cbs_smbus_regs_props.sv
// Port assertions for the clock buffer SMBus register bank
`timescale 1ns/1ps
module cbs_smbus_regs_props
	import cbs_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        sclIn,
	input wire logic        sdaIn,
	input wire logic        sdaOut,
	input wire logic        sdaOe,
	input wire logic [1:0]  addrSelA0,
	input wire logic [1:0]  addrSelA1,
	input wire logic        powergoodPowerdown_n,
	input wire logic        refClockRunning,
	input wire logic        freqSelectPin,
	input wire logic [1:0]  loopBandwidthSelectPin,
	input wire logic [11:0] outputEnablePin_n,
	input wire logic [11:0] diffClockRun,
	input wire logic        feedbackClockRun,
	input wire logic [1:0]  loopMode,
	input wire logic        freqSelect
);
	logic [2:0] pgCnt_r;
	wire        pgSeen = (pgCnt_r == 3'h7);
	// Counts power-good time so the strap latch has surely happened
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) pgCnt_r <= 3'h0;
		else if (powergoodPowerdown_n && !pgSeen) pgCnt_r <= pgCnt_r + 3'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_ref_idle: assert property (!refClockRunning [*6] |-> !sdaOe)
		else $error("SDA pulled while reference clock stopped");
	a_pg_off: assert property (!powergoodPowerdown_n [*5] |->
		diffClockRun == 12'h000 && !feedbackClockRun)
		else $error("outputs run during power down");
	a_pin_off: assert property ($stable(outputEnablePin_n) [*5] |->
		(diffClockRun & outputEnablePin_n) == 12'h000)
		else $error("pair runs with its enable pin high");
	a_fb_run: assert property ((powergoodPowerdown_n && refClockRunning) [*6] |->
		feedbackClockRun)
		else $error("feedback output not running");
	a_ack_len: assert property ($rose(sdaOe) |-> sdaOe [*6])
		else $error("SDA pull shorter than a bit");
	a_sda_steady: assert property (sclIn && $past(sclIn) && $past(refClockRunning, 4) |->
		$stable(sdaOe))
		else $error("SDA changed while SCL high");
	a_sda_low: assert property (sdaOe |-> !sdaOut)
		else $error("SDA driven high");
	a_freq_hold: assert property (pgSeen && $past(pgSeen) |-> $stable(freqSelect))
		else $error("latched frequency changed");
	a_loop_code: assert property (loopMode != 2'h2)
		else $error("illegal loop mode code");
	c_ack: cover property ($rose(sdaOe));
	c_pair_off: cover property (feedbackClockRun && diffClockRun != 12'hFFF);
	c_bypass: cover property (loopMode == LOOP_BYP);
endmodule // cbs_smbus_regs_props

// file: cbs_smbus_host.sv
// Behavioural SMBus host: starts, stops and bytes, SCL period 8 clocks
`timescale 1ns/1ps
module cbs_smbus_host (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Data moves only while SCL is low
	task automatic bitIo(input logic drv, output logic got);
		tick(2);
		sdaLow = ~drv;
		tick(2);
		scl = 1'b1;
		tick(2);
		got = sda;
		tick(2);
		scl = 1'b0;
	endtask
	task automatic start();
		tick(2);
		sdaLow = 1'b0;
		tick(6);
		scl = 1'b1;
		tick(4);
		sdaLow = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		tick(2);
		sdaLow = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sdaLow = 1'b0;
		tick(4);
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic x;
		for (int i = 7; i >= 0; i--) bitIo(b[i], x);
		bitIo(1'b1, x);
		ack = ~x;
	endtask
	// Acknowledge each byte, release SDA after the last
	task automatic recvByte(input logic last, output logic [7:0] b);
		logic x;
		for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
		bitIo(last, x);
	endtask
endmodule // cbs_smbus_host

// file: tb_top.sv
// Self-checking bench for the clock buffer SMBus register bank
`timescale 1ns/1ps
module tb_top
	import cbs_pkg::*;
;
	localparam logic [6:0] DEV = 7'h5D;
	localparam logic [7:0] VRC = 8'h39; // Arbitrary value
	localparam logic [7:0] PID = 8'h3C; // Arbitrary value
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        pg = 1'b0;
	logic        refRun = 1'b1;
	logic        freqPin = 1'b0;
	logic        fqL;
	logic [1:0]  strap = LOOP_LOW;
	logic [11:0] oePin_n = 12'h000;
	logic [7:0]  r1;
	logic [7:0]  ex[$];
	logic [1:0]  codes[3] = '{LOOP_LOW, LOOP_BYP, LOOP_HIGH};
	logic [11:0] expQ[$];
	logic [11:0] obsVal;
	string       obsNm;
	event        obsEv;
	int          n_errors = 0;
	int          n_compared = 0;
	int          seed = 32'h0000_7aae;
	wire         scl, hostLow, sdaOe, sdaOut, fb, fs;
	wire [11:0]  dcr;
	wire [1:0]   lm;
	wire         sda = !(sdaOe && !sdaOut) && !hostLow;
	always #10 clk = ~clk;
	cbs_smbus_regs #(.REV_CODE(VRC[7:4]), .VENDOR_ID(VRC[3:0]), .PART_ID(PID)) DUT (
		.clk                    (clk),
		.reset_n                (reset_n),
		.sclIn                  (scl),
		.sdaIn                  (sda),
		.sdaOut                 (sdaOut),
		.sdaOe                  (sdaOe),
		.addrSelA0              (2'h2),
		.addrSelA1              (TRI_MID),
		.powergoodPowerdown_n   (pg),
		.refClockRunning        (refRun),
		.freqSelectPin          (freqPin),
		.loopBandwidthSelectPin (strap),
		.outputEnablePin_n      (oePin_n),
		.diffClockRun           (dcr),
		.feedbackClockRun       (fb),
		.loopMode               (lm),
		.freqSelect             (fs)
	);
	cbs_smbus_host host (.clk(clk), .sda(sda), .scl(scl), .sdaLow(hostLow));
	task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	always @(obsEv) check(obsNm, obsVal, expQ.pop_front());
	function automatic void note(input logic [11:0] v);
		expQ.push_back(v);
	endfunction
	task automatic obs(input string nm, input logic [11:0] v);
		obsNm = nm;
		obsVal = v;
		->obsEv;
		#1;
	endtask
	task automatic sendAck(input logic [7:0] b, input logic ackExp);
		logic a;
		host.sendByte(b, a);
		note({11'h000, ackExp});
		obs("ack", {11'h000, a});
	endtask
	task automatic wrBlock(input logic [7:0] idx, input logic [7:0] d[$]);
		host.start();
		sendAck({DEV, 1'b0}, 1'b1);
		sendAck(idx, 1'b1);
		sendAck(8'(d.size()), 1'b1);
		foreach (d[i]) sendAck(d[i], 1'b1);
		host.stop();
	endtask
	task automatic rdBlock(input logic [7:0] idx, input logic [7:0] e[$]);
		logic [7:0] b;
		host.start();
		sendAck({DEV, 1'b0}, 1'b1);
		sendAck(idx, 1'b1);
		host.start();
		sendAck({DEV, 1'b1}, 1'b1);
		foreach (e[i]) begin
			host.recvByte(i == e.size() - 1, b);
			note({4'h0, e[i]});
			obs("readByte", {4'h0, b});
		end
		host.stop();
	endtask
	task automatic badAddr(input logic [6:0] a);
		host.start();
		sendAck({a, 1'b0}, 1'b0);
		host.stop();
	endtask
	task automatic ports(input logic [11:0] d, input logic f, input logic [1:0] m);
		repeat (8) @(negedge clk);
		note(d);
		obs("diffClockRun", dcr);
		note({11'h000, f});
		obs("feedbackClockRun", {11'h000, fb});
		note({10'h000, m});
		obs("loopMode", {10'h000, lm});
		note({11'h000, fqL});
		obs("freqSelect", {11'h000, fs});
	endtask
	task automatic close_out();
		if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_errors++;
		close_out();
	end
	initial begin
		strap = codes[$unsigned($random(seed)) % 3];
		freqPin = 1'($random(seed));
		fqL = freqPin;
		oePin_n = 12'($random(seed));
		r1 = 8'($random(seed));
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		pg = 1'b1;
		ports(~oePin_n, 1'b1, strap);
		ex = '{8'h09, {strap, 2'b00, RST_SW_SEL, RST_SW_MODE, fqL}, RST_OE_LOW,
			{4'h0, RST_OE_HIGH}, 8'h00, 8'h00, VRC, PID, {3'h0, RST_RBCNT}, 8'h00};
		rdBlock(8'h00, ex);
		foreach (codes[k]) begin
			ex = '{{4'h0, 1'b1, codes[k], 1'b0}};
			wrBlock(8'h00, ex);
			ports(~oePin_n, 1'b1, codes[k]);
		end
		ex = '{8'hFB, r1, 8'hF6, 8'hFF, 8'hFF, 8'hAA, 8'h55, 8'hE3, 8'hFF};
		wrBlock(8'h00, ex);
		ports({4'h6, r1} & ~oePin_n, 1'b1, LOOP_BYP);
		ex = '{8'h04, {strap, 2'b00, 1'b1, LOOP_BYP, fqL}, r1, 8'h06, 8'h00};
		rdBlock(8'h00, ex);
		ex = '{8'h04, VRC, PID, 8'h03, 8'h00};
		rdBlock(8'h05, ex);
		badAddr(DEV ^ 7'h01);
		refRun = 1'b0;
		ports(12'h000, 1'b0, LOOP_BYP);
		badAddr(DEV);
		refRun = 1'b1;
		pg = 1'b0;
		freqPin = ~fqL;
		ports(12'h000, 1'b0, LOOP_BYP);
		@(negedge clk);
		oePin_n = 12'($random(seed));
		pg = 1'b1;
		ports({4'h6, r1} & ~oePin_n, 1'b1, LOOP_BYP);
		close_out();
	end
endmodule // tb_top
bind cbs_smbus_regs cbs_smbus_regs_props u_props (
	.clk                    (clk),
	.reset_n                (reset_n),
	.sclIn                  (sclIn),
	.sdaIn                  (sdaIn),
	.sdaOut                 (sdaOut),
	.sdaOe                  (sdaOe),
	.addrSelA0              (addrSelA0),
	.addrSelA1              (addrSelA1),
	.powergoodPowerdown_n   (powergoodPowerdown_n),
	.refClockRunning        (refClockRunning),
	.freqSelectPin          (freqSelectPin),
	.loopBandwidthSelectPin (loopBandwidthSelectPin),
	.outputEnablePin_n      (outputEnablePin_n),
	.diffClockRun           (diffClockRun),
	.feedbackClockRun       (feedbackClockRun),
	.loopMode               (loopMode),
	.freqSelect             (freqSelect)
);
